// file: design/asc_channel.sv
// One asynchronous serial channel with its host register port and modem lines.
//
// Function
// - Divisor bytes replace offsets 0-1 when access set.
// - Data write loads; empty flag on move.
// - Start bit verified low at its centre.
// - Sample tick divides clock by 16-bit divisor.
// - Mask bits 0-3 gate four interrupt sources.
// - Mask bits 7-4 always zero.
// - Four priority levels: line, data, empty, modem.
// - Source bits 2:1 encode highest pending level.
// - Source read reports highest level only.
// - Source bit 0 low while any pending.
// - Source bits 3-7 read zero.
// - Format bits 1:0 pick 5-8 bit length.
// - Stop bits: one, one-and-half, or two.
// - Format bit 3 enables parity send/check.
// - Format bit 4 selects even or odd.
// - Stick parity fixed by bit 4 inverse.
// - Format bit 6 holds output low outside loop-back.
// - Control bits 0,1 drive ready/request low outside loop-back.
// - Control bit 2 only feeds loop-back.
// - Control bit 3 enables interrupt pin driver.
// - Line bit 0 shows held received character.
// - Serial output mark in reset and loop.
`include "asc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module asc_channel #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire asc_pkg::asc_bus_s bus,
  input wire logic rx,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic [7:0] rd_data,
  output logic rd_oe,
  output logic tx,
  output logic dtr_n,
  output logic rts_n,
  output logic irq,
  output logic irq_oe
);

  asc_pkg::asc_fmt_s fmt_q;
  logic [3:0] mask_q;
  logic [4:0] hsc_q;
  logic [7:0] scr_q, div_lo_q, div_hi_q, thr_q, rbr_q;
  logic rd_act_q, wr_act_q;
  logic baud_tick;

  // Strobes are level inputs; each access acts once, on its first cycle.
  wire rd_act = ~bus.cs_n & ~bus.read_strobe_n;
  wire wr_act = ~bus.cs_n & ~bus.write_strobe_n;
  wire rd_go = rd_act & ~rd_act_q;
  wire wr_go = wr_act & ~wr_act_q;
  wire dl = fmt_q.divisor_access;
  wire a_data = (bus.addr == `ASC_OFF_DATA);
  wire a_mask = (bus.addr == `ASC_OFF_MASK);
  wire wr_thr = wr_go & a_data & ~dl;
  wire wr_dll = wr_go & a_data & dl;
  wire wr_dlm = wr_go & a_mask & dl;
  wire wr_ier = wr_go & a_mask & ~dl;
  wire wr_fmt = wr_go & (bus.addr == `ASC_OFF_FMT);
  wire wr_hsc = wr_go & (bus.addr == `ASC_OFF_HSC);
  wire wr_scr = wr_go & (bus.addr == `ASC_OFF_SCR);
  wire rd_rbr = rd_go & a_data & ~dl;
  wire rd_isr = rd_go & (bus.addr == `ASC_OFF_SRC);
  wire rd_lsr = rd_go & (bus.addr == `ASC_OFF_LINE);
  wire rd_msr = rd_go & (bus.addr == `ASC_OFF_HSI);
  wire loop = hsc_q[`ASC_HSC_LOOP];

  // Bus edge detection.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  // Host-written control registers; unused upper bits are never stored.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fmt_q <= `ASC_RST_BYTE;
      mask_q <= `ASC_RST_MASK;
      hsc_q <= `ASC_RST_HSC;
      scr_q <= `ASC_RST_BYTE;
      div_lo_q <= `ASC_RST_BYTE;
      div_hi_q <= `ASC_RST_BYTE;
    end else begin
      if (wr_fmt) fmt_q <= bus.wdata;
      if (wr_ier) mask_q <= bus.wdata[3:0];
      if (wr_hsc) hsc_q <= bus.wdata[4:0];
      if (wr_scr) scr_q <= bus.wdata;
      if (wr_dll) div_lo_q <= bus.wdata;
      if (wr_dlm) div_hi_q <= bus.wdata;
    end
  end

  // Sixteen-times sample enable from the two divisor bytes.
  asc_baud #(.DIV_W(DIV_W)) u_baud (
    .clk(clk),
    .resetn(resetn),
    .divisor(DIV_W'({div_hi_q, div_lo_q})),
    .tick(baud_tick)
  );

  // Frame format decoding; the length is shared by both directions, the mask and stop period serve the transmitter.
  wire [2:0] last_bit = {1'b0, fmt_q.wlen} + `ASC_BASE_LEN;
  wire [7:0] len_mask = 8'hff >> (3'h3 - {1'b0, fmt_q.wlen});
  wire [5:0] stop_lim = !fmt_q.stop2 ? `ASC_TICKS_BIT :
                        (fmt_q.wlen == 2'h0) ? `ASC_TICKS_STOP15 : `ASC_TICKS_STOP2;

  // Parity of a character; stick mode sends the inverse of the even bit.
  function automatic logic par_of(input logic [7:0] d, input asc_pkg::asc_fmt_s f);
    logic p;
    p = ^d;
    if (f.stick) begin
      par_of = ~f.even;
    end else begin
      par_of = f.even ? p : ~p;
    end
  endfunction

  // Transmitter.
  asc_pkg::asc_tx_e tx_st_q;
  logic [7:0] tsr_q;
  logic [2:0] tx_bit_q;
  logic [5:0] tx_cnt_q;
  logic tx_par_q, thre_q, thre_prev_q;
  wire [5:0] tx_lim = (tx_st_q == asc_pkg::ASC_TX_STOP) ? stop_lim : `ASC_TICKS_BIT;
  wire tx_end = baud_tick & (tx_cnt_q == tx_lim - 6'h1);
  wire tx_load = (tx_st_q == asc_pkg::ASC_TX_IDLE) & ~thre_q;
  wire temt = thre_q & (tx_st_q == asc_pkg::ASC_TX_IDLE);
  logic tx_line;

  // Serial level for each part of the frame.
  always_comb begin
    case (tx_st_q)
      asc_pkg::ASC_TX_START: tx_line = 1'b0;
      asc_pkg::ASC_TX_DATA: tx_line = tsr_q[0];
      asc_pkg::ASC_TX_PAR: tx_line = tx_par_q;
      default: tx_line = 1'b1;
    endcase
  end

  // Holding register: a host write fills it, the move to the shifter empties it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      thr_q <= `ASC_RST_BYTE;
      thre_q <= 1'b1;
    end else if (wr_thr) begin
      thr_q <= bus.wdata;
      thre_q <= 1'b0;
    end else if (tx_load) begin
      thre_q <= 1'b1;
    end
  end

  // Frame sequencer; parity is worked out once, as the byte is moved.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_st_q <= asc_pkg::ASC_TX_IDLE;
      tsr_q <= `ASC_RST_BYTE;
      tx_bit_q <= 3'h0;
      tx_cnt_q <= 6'h0;
      tx_par_q <= 1'b0;
    end else begin
      if (baud_tick) tx_cnt_q <= tx_end ? 6'h0 : tx_cnt_q + 6'h1;
      case (tx_st_q)
        asc_pkg::ASC_TX_IDLE: begin
          tx_cnt_q <= 6'h0;
          if (tx_load) begin
            tsr_q <= thr_q;
            tx_par_q <= par_of(thr_q & len_mask, fmt_q);
            tx_st_q <= asc_pkg::ASC_TX_START;
          end
        end
        asc_pkg::ASC_TX_START: begin
          tx_bit_q <= 3'h0;
          if (tx_end) tx_st_q <= asc_pkg::ASC_TX_DATA;
        end
        asc_pkg::ASC_TX_DATA: begin
          if (tx_end) begin
            tsr_q <= tsr_q >> 1;
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == last_bit) begin
              tx_st_q <= fmt_q.pen ? asc_pkg::ASC_TX_PAR : asc_pkg::ASC_TX_STOP;
            end
          end
        end
        asc_pkg::ASC_TX_PAR: begin
          if (tx_end) tx_st_q <= asc_pkg::ASC_TX_STOP;
        end
        asc_pkg::ASC_TX_STOP: begin
          if (tx_end) tx_st_q <= asc_pkg::ASC_TX_IDLE;
        end
        default: tx_st_q <= asc_pkg::ASC_TX_IDLE;
      endcase
    end
  end

  // Receiver; in loop-back it listens to its own transmitter.
  asc_pkg::asc_rx_e rx_st_q;
  logic [7:0] rsr_q;
  logic [2:0] rx_bit_q;
  logic [3:0] rx_cnt_q;
  logic rx_prev_q, rx_par_q, rx_zero_q;
  logic dr_q, ovr_q, pe_q, fe_q, bi_q;
  wire rx_in = loop ? (tx_line & ~fmt_q.brk) : rx;
  wire rx_ctr = baud_tick & (rx_cnt_q == `ASC_RX_CTR);
  wire rx_done = (rx_st_q == asc_pkg::ASC_RX_STOP) & rx_ctr;

  // Start detect, bit sampling and character assembly.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_st_q <= asc_pkg::ASC_RX_IDLE;
      rsr_q <= `ASC_RST_BYTE;
      rbr_q <= `ASC_RST_BYTE;
      rx_bit_q <= 3'h0;
      rx_cnt_q <= 4'h0;
      rx_prev_q <= 1'b1;
      rx_par_q <= 1'b0;
      rx_zero_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_in;
      if (baud_tick) rx_cnt_q <= rx_cnt_q + 4'h1;
      case (rx_st_q)
        asc_pkg::ASC_RX_IDLE: begin
          rx_cnt_q <= 4'h0;
          if (rx_prev_q & ~rx_in) rx_st_q <= asc_pkg::ASC_RX_START;
        end
        asc_pkg::ASC_RX_START: begin
          if (baud_tick && rx_cnt_q == `ASC_RX_MID) begin
            // A glitch shorter than half a bit is dropped here.
            rx_st_q <= rx_in ? asc_pkg::ASC_RX_IDLE : asc_pkg::ASC_RX_DATA;
            rx_cnt_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rsr_q <= `ASC_RST_BYTE;
            rx_zero_q <= 1'b1;
          end
        end
        asc_pkg::ASC_RX_DATA: begin
          if (rx_ctr) begin
            rsr_q[rx_bit_q] <= rx_in;
            rx_zero_q <= rx_zero_q & ~rx_in;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) begin
              rx_st_q <= fmt_q.pen ? asc_pkg::ASC_RX_PAR : asc_pkg::ASC_RX_STOP;
            end
          end
        end
        asc_pkg::ASC_RX_PAR: begin
          if (rx_ctr) begin
            rx_par_q <= rx_in;
            rx_zero_q <= rx_zero_q & ~rx_in;
            rx_st_q <= asc_pkg::ASC_RX_STOP;
          end
        end
        asc_pkg::ASC_RX_STOP: begin
          if (rx_ctr) begin
            rbr_q <= rsr_q;
            rx_st_q <= asc_pkg::ASC_RX_IDLE;
          end
        end
        default: rx_st_q <= asc_pkg::ASC_RX_IDLE;
      endcase
    end
  end

  // Line status: a new event in the cycle of the clearing read still sets.
  wire pe_set = rx_done & fmt_q.pen & (rx_par_q != par_of(rsr_q, fmt_q));
  wire fe_set = rx_done & ~rx_in;
  wire bi_set = rx_done & rx_zero_q & ~rx_in;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dr_q <= 1'b0;
      ovr_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
    end else begin
      dr_q <= rx_done | (dr_q & ~rd_rbr);
      ovr_q <= (rx_done & dr_q & ~rd_rbr) | (ovr_q & ~rd_lsr);
      pe_q <= pe_set | (pe_q & ~rd_lsr);
      fe_q <= fe_set | (fe_q & ~rd_lsr);
      bi_q <= bi_set | (bi_q & ~rd_lsr);
    end
  end

  // Modem inputs; loop-back substitutes the control bits.
  logic [3:0] ms_q, dms_q;
  logic ms_prime_q;
  wire [3:0] ms_now = loop ? {hsc_q[`ASC_HSC_INTEN], hsc_q[`ASC_HSC_OUT1],
                              hsc_q[`ASC_HSC_DTR], hsc_q[`ASC_HSC_RTS]}
                           : ~{cd_n, ri_n, dsr_n, cts_n};
  wire [3:0] ms_chg = ms_now ^ ms_q;
  wire [3:0] dms_set = {ms_chg[3], ms_q[2] & ~ms_now[2], ms_chg[1:0]} & {4{ms_prime_q}};
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ms_q <= 4'h0;
      dms_q <= 4'h0;
      ms_prime_q <= 1'b0;
    end else begin
      ms_q <= ms_now;
      ms_prime_q <= 1'b1;
      dms_q <= dms_set | (rd_msr ? 4'h0 : dms_q);
    end
  end

  // Interrupt sources ranked; the empty source clears on a report or a write.
  logic the_int_q;
  wire ls_p = mask_q[`ASC_MASK_LS] & (ovr_q | pe_q | fe_q | bi_q);
  wire rda_p = mask_q[`ASC_MASK_RDA] & dr_q;
  wire the_p = mask_q[`ASC_MASK_THE] & the_int_q;
  wire ms_p = mask_q[`ASC_MASK_MS] & (|dms_q);
  logic [7:0] isr_val;
  always_comb begin
    if (ls_p) begin
      isr_val = {5'h00, `ASC_SRC_LS, 1'b0};
    end else if (rda_p) begin
      isr_val = {5'h00, `ASC_SRC_RDA, 1'b0};
    end else if (the_p) begin
      isr_val = {5'h00, `ASC_SRC_THE, 1'b0};
    end else if (ms_p) begin
      isr_val = {5'h00, `ASC_SRC_MS, 1'b0};
    end else begin
      isr_val = `ASC_SRC_NONE;
    end
  end
  wire the_rpt = rd_isr & ~isr_val[0] & (isr_val[2:1] == `ASC_SRC_THE);
  wire the_set = (thre_q & ~thre_prev_q) |
                 (wr_ier & bus.wdata[`ASC_MASK_THE] & ~mask_q[`ASC_MASK_THE] & thre_q);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      the_int_q <= 1'b0;
      thre_prev_q <= 1'b1;
    end else begin
      thre_prev_q <= thre_q;
      the_int_q <= the_set | (the_int_q & ~the_rpt & ~wr_thr);
    end
  end

  // Read selection.
  logic [7:0] rsel;
  always_comb begin
    case (bus.addr)
      `ASC_OFF_DATA: rsel = dl ? div_lo_q : rbr_q;
      `ASC_OFF_MASK: rsel = dl ? div_hi_q : {4'h0, mask_q};
      `ASC_OFF_SRC: rsel = isr_val;
      `ASC_OFF_FMT: rsel = fmt_q;
      `ASC_OFF_HSC: rsel = {3'h0, hsc_q};
      `ASC_OFF_LINE: rsel = {1'b0, temt, thre_q, bi_q, fe_q, pe_q, ovr_q, dr_q};
      `ASC_OFF_HSI: rsel = {ms_q, dms_q};
      default: rsel = scr_q;
    endcase
  end

  // Read data is frozen at the start of the access, before clear-on-read.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data <= `ASC_RST_BYTE;
      rd_oe <= 1'b0;
    end else begin
      rd_oe <= rd_act;
      if (rd_go) rd_data <= rsel;
    end
  end

  // Pin outputs; modem lines go inactive in loop-back so the far side sees idle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx <= 1'b1;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      irq <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      tx <= loop | (~fmt_q.brk & tx_line);
      dtr_n <= loop | ~hsc_q[`ASC_HSC_DTR];
      rts_n <= loop | ~hsc_q[`ASC_HSC_RTS];
      irq <= ~isr_val[0];
      irq_oe <= hsc_q[`ASC_HSC_INTEN];
    end
  end

endmodule
`default_nettype wire

// file: design/asc_params.svh
// Register offsets, field positions, reset values and bit timing of the serial channel.
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// Register offsets on the three address lines.
`define ASC_OFF_DATA 3'h0
`define ASC_OFF_MASK 3'h1
`define ASC_OFF_SRC 3'h2
`define ASC_OFF_FMT 3'h3
`define ASC_OFF_HSC 3'h4
`define ASC_OFF_LINE 3'h5
`define ASC_OFF_HSI 3'h6
`define ASC_OFF_SCR 3'h7

// Reset values.
`define ASC_RST_BYTE 8'h00
`define ASC_RST_MASK 4'h0
`define ASC_RST_HSC 5'h00

// Handshake control fields.
`define ASC_HSC_DTR 0
`define ASC_HSC_RTS 1
`define ASC_HSC_OUT1 2
`define ASC_HSC_INTEN 3
`define ASC_HSC_LOOP 4

// Interrupt mask fields.
`define ASC_MASK_RDA 0
`define ASC_MASK_THE 1
`define ASC_MASK_LS 2
`define ASC_MASK_MS 3

// Interrupt source codes in bits 2:1, and the idle reading.
`define ASC_SRC_LS 2'h3
`define ASC_SRC_RDA 2'h2
`define ASC_SRC_THE 2'h1
`define ASC_SRC_MS 2'h0
`define ASC_SRC_NONE 8'h01

// Sample ticks per bit, per stop period, and receiver sample points.
`define ASC_TICKS_BIT 6'h10
`define ASC_TICKS_STOP15 6'h18
`define ASC_TICKS_STOP2 6'h20
`define ASC_RX_MID 4'h7
`define ASC_RX_CTR 4'hf
`define ASC_BASE_LEN 3'h4

`endif

// file: design/asc_pkg.sv
// Types shared by the serial channel modules.
package asc_pkg;

  // Host bus request as sampled on the pins.
  typedef struct packed {
    logic [2:0] addr;
    logic cs_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [7:0] wdata;
  } asc_bus_s;

  // Frame format register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic divisor_access;
    logic brk;
    logic stick;
    logic even;
    logic pen;
    logic stop2;
    logic [1:0] wlen;
  } asc_fmt_s;

  typedef enum logic [2:0] {ASC_TX_IDLE, ASC_TX_START, ASC_TX_DATA, ASC_TX_PAR,
                            ASC_TX_STOP} asc_tx_e;
  typedef enum logic [2:0] {ASC_RX_IDLE, ASC_RX_START, ASC_RX_DATA, ASC_RX_PAR,
                            ASC_RX_STOP} asc_rx_e;

endpackage

// file: design/asc_baud.sv
// Baud generator: one-cycle enable at sixteen times the bit rate.
`timescale 1ns/1ps
`default_nettype none
module asc_baud #(
  parameter int DIV_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);

  logic [DIV_W-1:0] cnt_q;
  wire div_zero = (divisor == '0);
  wire wrap = (cnt_q >= divisor - 1'b1);

  // A zero divisor stops the generator; a divisor of one ticks every cycle.
  always_ff @(posedge clk) begin
    if (!resetn || div_zero) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 1'b1;
      tick <= wrap;
    end
  end

endmodule
`default_nettype wire

// file: dv/asc_remote.sv
// Remote serial transceiver model: sends frames on rx and captures frames from tx.
`timescale 1ns/1ps
`default_nettype none
module asc_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk,
  input wire logic tx,
  output var logic rx
);
  initial rx = 1'b1;

  // Start bit, then n bits LSB first; the line rests at mark afterwards.
  task automatic send(input logic [11:0] bits, input int n);
    rx <= 1'b0;
    repeat (BIT_CLKS) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      rx <= bits[i];
      repeat (BIT_CLKS) @(negedge clk);
    end
    rx <= 1'b1;
  endtask

  // A low pulse far shorter than half a bit, which a receiver must reject.
  task automatic spike(input int k);
    rx <= 1'b0;
    repeat (k) @(negedge clk);
    rx <= 1'b1;
  endtask

  // Waits for a start bit and samples it and n further bits at their centres.
  task automatic grab(input int n, output logic [11:0] bits, output bit ok);
    int w;
    bits = 12'h000;
    ok = 1'b0;
    w = 0;
    // Falling edges keep every look half a cycle clear of the edge that moves tx.
    while (tx !== 1'b0 && w < 4000) begin
      @(negedge clk);
      w++;
    end
    repeat (BIT_CLKS / 2) @(negedge clk);
    ok = (tx === 1'b0) && (w < 4000);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CLKS) @(negedge clk);
      bits[i] = tx;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/asc_channel_asserts.sv
// Port-level checker for the serial channel, bound to its top module.
`include "asc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module asc_channel_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire asc_pkg::asc_bus_s bus,
  input wire logic rx,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  input wire logic [7:0] rd_data,
  input wire logic rd_oe,
  input wire logic tx,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic irq,
  input wire logic irq_oe
);
  logic wr_q;
  logic rd_q;
  logic [1:0] calm_q;
  logic [7:0] fmt_q;
  logic [7:0] hsc_q;
  logic [7:0] scr_q;
  logic [3:0] mask_q;
  // Access starts are edges of the strobe condition, as the port takes them.
  wire wr_go = !bus.cs_n && !bus.write_strobe_n && !wr_q;
  wire rd_go = !bus.cs_n && !bus.read_strobe_n && !rd_q;
  wire ctl_wr = wr_go && (bus.addr == `ASC_OFF_FMT || bus.addr == `ASC_OFF_HSC);
  wire loop = hsc_q[4];

  // Shadow copies; calm_q gives outputs three cycles to settle after a control write.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      calm_q <= 2'h3;
      fmt_q <= 8'h00;
      hsc_q <= 8'h00;
      scr_q <= 8'h00;
      mask_q <= 4'h0;
    end else begin
      wr_q <= !bus.cs_n && !bus.write_strobe_n;
      rd_q <= !bus.cs_n && !bus.read_strobe_n;
      calm_q <= ctl_wr ? 2'h0 : (calm_q == 2'h3 ? 2'h3 : calm_q + 2'h1);
      if (wr_go && bus.addr == `ASC_OFF_FMT) fmt_q <= bus.wdata;
      if (wr_go && bus.addr == `ASC_OFF_HSC) hsc_q <= bus.wdata;
      if (wr_go && bus.addr == `ASC_OFF_SCR) scr_q <= bus.wdata;
      if (wr_go && bus.addr == `ASC_OFF_MASK && !fmt_q[7]) mask_q <= bus.wdata[3:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_dtr; calm_q == 2'h3 |-> dtr_n == !(hsc_q[0] && !loop); endproperty
  property p_rts; calm_q == 2'h3 |-> rts_n == !(hsc_q[1] && !loop); endproperty
  property p_irq_oe; calm_q == 2'h3 |-> irq_oe == hsc_q[3]; endproperty
  property p_brk; calm_q == 2'h3 && fmt_q[6] && !loop |-> !tx [*2]; endproperty
  property p_loop_mark; calm_q == 2'h3 && loop |-> tx; endproperty
  property p_src; rd_go && bus.addr == `ASC_OFF_SRC
    |=> rd_oe && rd_data[7:3] == 5'h00 && (!rd_data[0] || rd_data[2:1] == 2'h0); endproperty
  property p_mask; rd_go && bus.addr == `ASC_OFF_MASK && !fmt_q[7]
    |=> rd_data == {4'h0, mask_q}; endproperty
  property p_scr; rd_go && bus.addr == `ASC_OFF_SCR |=> rd_data == scr_q; endproperty
  property p_irq; $rose(irq) |-> mask_q != 4'h0; endproperty

  a_dtr: assert property (p_dtr) else $error("dtr_n differs from control");
  a_rts: assert property (p_rts) else $error("rts_n differs from control");
  a_irq_oe: assert property (p_irq_oe) else $error("irq_oe differs");
  a_brk: assert property (p_brk) else $error("break not low");
  a_loop_mark: assert property (p_loop_mark) else $error("tx not mark in loop");
  a_src: assert property (p_src) else $error("source byte malformed");
  a_mask: assert property (p_mask) else $error("mask readback wrong");
  a_scr: assert property (p_scr) else $error("scratch readback wrong");
  a_irq: assert property (p_irq) else $error("irq rose with all masked");

  c_src: cover property (rd_go && bus.addr == `ASC_OFF_SRC);
  c_brk: cover property (calm_q == 2'h3 && fmt_q[6]);
  c_loop: cover property (calm_q == 2'h3 && loop);
endmodule
bind asc_channel asc_channel_asserts u_chk (.clk(clk), .resetn(resetn), .bus(bus), .rx(rx),
  .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .rd_data(rd_data), .rd_oe(rd_oe),
  .tx(tx), .dtr_n(dtr_n), .rts_n(rts_n), .irq(irq), .irq_oe(irq_oe));
`default_nettype wire

// file: dv/tb.sv
// Self-checking testbench of the serial channel against a remote transceiver model.
`include "asc_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  asc_pkg::asc_bus_s bus = '{3'h0, 1'b1, 1'b1, 1'b1, 8'h00};
  logic cts_n = 1'b1;
  logic dsr_n = 1'b1;
  logic ri_n = 1'b1;
  logic cd_n = 1'b1;
  wire logic rx;
  logic [7:0] rd_data;
  logic rd_oe, tx, dtr_n, rts_n, irq, irq_oe;
  int bad_count = 0;
  int compares = 0;
  logic [31:0] seed = 32'h1;
  logic [7:0] v;
  logic [11:0] fr, got;
  bit ok;
  int n;
  logic [7:0] hs [5] = '{8'h01, 8'h02, 8'h04, 8'h0b, 8'h00};
  logic [7:0] fm [7] = '{8'h00, 8'h05, 8'h0a, 8'h1b, 8'h2f, 8'h3a, 8'h0c};

  always #5 clk = ~clk;

  asc_channel dut (.clk(clk), .resetn(resetn), .bus(bus), .rx(rx), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .rd_data(rd_data), .rd_oe(rd_oe), .tx(tx),
    .dtr_n(dtr_n), .rts_n(rts_n), .irq(irq), .irq_oe(irq_oe));
  // Divisor 2 gives 16 ticks of 2 clocks, so 32 clocks a bit.
  asc_remote #(.BIT_CLKS(32)) u_remote (.clk(clk), .tx(tx), .rx(rx));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Bits after the start bit: data LSB first, parity if enabled, then the stop marks.
  function automatic logic [11:0] frame(input logic [7:0] f, input logic [7:0] d,
                                        output int n);
    logic [11:0] r;
    int len;
    len = 5 + int'(f[1:0]);
    d = d & (8'hff >> (8 - len));
    r = {4'h0, d};
    n = len;
    if (f[3]) begin
      r[n] = f[5] ? !f[4] : (f[4] ? ^d : !(^d));
      n = n + 1;
    end
    r[n] = 1'b1;
    n = n + 1;
    if (f[2] && len > 5) begin
      r[n] = 1'b1;
      n = n + 1;
    end
    return r;
  endfunction

  // Inputs change only at falling edges; every access leaves an idle cycle after it.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus <= '{a, 1'b0, 1'b1, 1'b0, d};
    @(negedge clk);
    bus <= '{a, 1'b1, 1'b1, 1'b1, d};
    @(negedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    bus <= '{a, 1'b0, 1'b0, 1'b1, 8'h00};
    repeat (2) @(negedge clk);
    q = rd_data;
    bus <= '{a, 1'b1, 1'b1, 1'b1, 8'h00};
    @(negedge clk);
  endtask

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    `CHK(q, e)
  endtask

  // Polls line_state until all bits of m are set, under a bounded count.
  task automatic wait_line(input logic [7:0] m);
    logic [7:0] q;
    q = 8'h00;
    for (int k = 0; k < 300 && (q & m) !== m; k++) rd(`ASC_OFF_LINE, q);
    `CHK(q & m, m)
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #500us;
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (5) @(negedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    `CHK({tx, dtr_n, rts_n, irq_oe}, 4'he)
    chk_rd(`ASC_OFF_SRC, `ASC_SRC_NONE);
    chk_rd(`ASC_OFF_LINE, 8'h60);
    for (int i = 0; i < 4; i++) begin
      v = 8'(rnd());
      wr(`ASC_OFF_SCR, v);
      chk_rd(`ASC_OFF_SCR, v);
    end
    wr(`ASC_OFF_MASK, 8'hf5);
    chk_rd(`ASC_OFF_MASK, 8'h05);
    wr(`ASC_OFF_FMT, 8'h80);
    wr(`ASC_OFF_DATA, 8'h02);
    wr(`ASC_OFF_MASK, 8'h00);
    chk_rd(`ASC_OFF_LINE, 8'h60);
    wr(`ASC_OFF_FMT, 8'h03);
    chk_rd(`ASC_OFF_MASK, 8'h05);
    $display("test registers done");
    foreach (hs[i]) begin
      wr(`ASC_OFF_HSC, hs[i]);
      repeat (3) @(negedge clk);
      `CHK({dtr_n, rts_n, irq_oe}, {!hs[i][0], !hs[i][1], hs[i][3]})
    end
    wr(`ASC_OFF_HSC, 8'h13);
    repeat (3) @(negedge clk);
    `CHK({tx, dtr_n, rts_n}, 3'h7)
    chk_rd(`ASC_OFF_HSI, 8'h33);
    wr(`ASC_OFF_HSC, 8'h08);
    rd(`ASC_OFF_HSI, v);
    $display("test handshake done");
    wr(`ASC_OFF_MASK, 8'h02);
    foreach (fm[i]) begin
      v = 8'(rnd());
      wr(`ASC_OFF_FMT, fm[i]);
      wait_line(8'h20);
      wr(`ASC_OFF_DATA, v);
      fr = frame(fm[i], v, n);
      u_remote.grab(n, got, ok);
      `CHK(ok, 1'b1)
      `CHK(got, fr)
      wait_line(8'h40);
      `CHK(irq, 1'b1)
      chk_rd(`ASC_OFF_SRC, 8'h02);
    end
    wr(`ASC_OFF_FMT, 8'h43);
    repeat (3) @(negedge clk);
    `CHK(tx, 1'b0)
    wr(`ASC_OFF_FMT, 8'h1b);
    $display("test transmit done");
    // Re-enabling the empty source while empty leaves it pending under received data.
    wr(`ASC_OFF_MASK, 8'h05);
    wr(`ASC_OFF_MASK, 8'h07);
    v = 8'(rnd());
    fr = frame(8'h1b, v, n);
    u_remote.send(fr, n);
    chk_rd(`ASC_OFF_SRC, 8'h04);
    chk_rd(`ASC_OFF_LINE, 8'h61);
    chk_rd(`ASC_OFF_DATA, v);
    chk_rd(`ASC_OFF_SRC, 8'h02);
    u_remote.send(fr ^ 12'h100, n);
    chk_rd(`ASC_OFF_SRC, 8'h06);
    chk_rd(`ASC_OFF_LINE, 8'h65);
    chk_rd(`ASC_OFF_SRC, 8'h04);
    chk_rd(`ASC_OFF_DATA, v);
    chk_rd(`ASC_OFF_SRC, `ASC_SRC_NONE);
    u_remote.spike(8);
    // A wrongly accepted start would complete a frame within 400 clocks.
    repeat (400) @(negedge clk);
    chk_rd(`ASC_OFF_LINE, 8'h60);
    $display("test receive done");
    wr(`ASC_OFF_MASK, 8'h08);
    cts_n <= 1'b0;
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b1)
    chk_rd(`ASC_OFF_SRC, 8'h00);
    chk_rd(`ASC_OFF_HSI, 8'h11);
    chk_rd(`ASC_OFF_SRC, `ASC_SRC_NONE);
    $display("test modem done");
    end_sim();
  end
endmodule
`default_nettype wire
